/* File: hw/ext_decode_regs.svh */
// opcode patterns, field slices, limits and reset values of the extended
// instruction decoder; included by bare name, holds definitions only
`ifndef EXT_DECODE_REGS_SVH
`define EXT_DECODE_REGS_SVH
// field slices of a program word
`define FLD_OP8 15:8
`define FLD_OP7 15:9
`define FLD_OP6 15:10
`define FLD_OP4 15:12
`define FLD_SEL 7:6
`define FLD_K6 5:0
`define FLD_K8 7:0
`define FLD_Z 6:0
`define FLD_SS 7
`define FLD_FD 11:0
`define FLD_ACC 8
`define FLD_F 7:0
// opcode patterns
`define OPC_PTR_ADD 8'hE8
`define OPC_PTR_SUB 8'hE9
`define OPC_PUSH_LIT 8'hEA
`define OPC_MOVE_STK 8'hEB
`define OPC_CALL_W 16'h0014
`define OPC_CMP_GT 7'h32
`define OPC_CMP_LT 7'h30
`define OPC_SECOND 4'hF
`define OPC_MOVE_FF 4'hC
`define OPC_LOAD_PTR 8'hEE
`define OPC_CALL_ABS 7'h76
`define OPC_GOTO_ABS 8'hEF
`define OPC_BYTE_LO 4'h1
`define OPC_BYTE_HI 4'hB
`define OPC_DEC_GRP 6'h01
`define OPC_MUL_GRP 7'h01
// pointer selection and addressing limits
`define FRAME_SEL 2'h2
`define FRAME_RET_SEL 2'h3
`define ACCESS_LIMIT 8'h5F
`define ACCESS_LO_BANK 4'h0
`define ACCESS_HI_BANK 4'hF
// reset and step values
`define PTR_RESET 12'h000
`define PTR_STEP 12'h001
`define EXT_ERASED 1'b1
`endif

/* File: hw/ext_decode_pkg.sv */
// types shared by the extended instruction decoder and its classifier
// assumes ext_decode_regs.svh is on the include path
`include "ext_decode_regs.svh"
package ext_decode_pkg;

  typedef enum logic [3:0] {
    op_none,
    op_base,
    op_ptr_add,
    op_ptr_sub,
    op_frame_add_ret,
    op_frame_sub_ret,
    op_call_w,
    op_push_lit,
    op_move_sf,
    op_move_ss,
    op_cmp_gt,
    op_cmp_lt
  } op_kind_t;

  typedef enum logic [2:0] {
    st_idle,
    st_hold,
    st_second,
    st_skip,
    st_skip_tail
  } phase_t;

  typedef struct packed {
    op_kind_t kind;
    logic [1:0] sel;
    logic [5:0] k6;
    logic [7:0] k8;
    logic [6:0] z;
    logic [7:0] f;
    logic acc;
    logic byte_op;
    logic indexed;
    logic two_word;
  } decode_t;

  typedef struct packed {
    phase_t phase;
    logic ext_on;
    logic cfg_done;
    logic busy;
    logic [2:0][11:0] ptr;
    logic mem_re;
    logic [11:0] raddr;
    logic pair_ss;
    logic mem_we;
    logic [11:0] waddr;
    logic [7:0] wdata;
    logic ret;
    logic call;
    logic [20:0] target;
    logic [20:0] push_addr;
    logic skip;
    logic oper_valid;
    logic [11:0] oper_addr;
  } core_t;

endpackage

/* File: hw/decode_if.sv */
// carrier between the decoder core and its word classifier
// assumes ext_decode_pkg is compiled first
`timescale 1ns/1ns
interface decode_if;
  logic [15:0] word;
  logic ext_en;
  ext_decode_pkg::decode_t d;
  modport dec (input word, input ext_en, output d);
  modport exe (output word, output ext_en, input d);
endinterface

/* File: hw/instruction_classifier.sv */
// combinational classifier of one program word into operation and fields
// assumes the word and the extension enable come from the mclk domain
`timescale 1ns/1ns
`include "ext_decode_regs.svh"
module instruction_classifier (
  decode_if.dec bus
);

  ext_decode_pkg::decode_t d;
  logic [15:0] w;

  always_comb begin
    w = bus.word;
    d = '0;
    d.sel = w[`FLD_SEL];
    d.k6 = w[`FLD_K6];
    d.k8 = w[`FLD_K8];
    d.z = w[`FLD_Z];
    d.f = w[`FLD_F];
    d.acc = w[`FLD_ACC];
    d.byte_op = (w[`FLD_OP4] >= `OPC_BYTE_LO && w[`FLD_OP4] <= `OPC_BYTE_HI)
      || w[`FLD_OP6] == `OPC_DEC_GRP || w[`FLD_OP7] == `OPC_MUL_GRP;
    // low access operands turn into frame offsets
    d.indexed = bus.ext_en && d.byte_op && !d.acc && d.f <= `ACCESS_LIMIT;
    d.two_word = w[`FLD_OP4] == `OPC_MOVE_FF
      || w[`FLD_OP8] == `OPC_LOAD_PTR || w[`FLD_OP7] == `OPC_CALL_ABS
      || w[`FLD_OP8] == `OPC_GOTO_ABS
      || (bus.ext_en && w[`FLD_OP8] == `OPC_MOVE_STK);
    d.kind = ext_decode_pkg::op_base;
    if (bus.ext_en && w == `OPC_CALL_W) begin
      d.kind = ext_decode_pkg::op_call_w;
    end else if (bus.ext_en && w[`FLD_OP8] == `OPC_PTR_ADD) begin
      d.kind = (d.sel == `FRAME_RET_SEL) ? ext_decode_pkg::op_frame_add_ret
                                         : ext_decode_pkg::op_ptr_add;
    end else if (bus.ext_en && w[`FLD_OP8] == `OPC_PTR_SUB) begin
      d.kind = (d.sel == `FRAME_RET_SEL) ? ext_decode_pkg::op_frame_sub_ret
                                         : ext_decode_pkg::op_ptr_sub;
    end else if (bus.ext_en && w[`FLD_OP8] == `OPC_PUSH_LIT) begin
      d.kind = ext_decode_pkg::op_push_lit;
    end else if (bus.ext_en && w[`FLD_OP8] == `OPC_MOVE_STK) begin
      d.kind = w[`FLD_SS] ? ext_decode_pkg::op_move_ss
                          : ext_decode_pkg::op_move_sf;
    end else if (w[`FLD_OP7] == `OPC_CMP_GT) begin
      d.kind = ext_decode_pkg::op_cmp_gt;
    end else if (w[`FLD_OP7] == `OPC_CMP_LT) begin
      d.kind = ext_decode_pkg::op_cmp_lt;
    end
    bus.d = d;
  end

endmodule

/* File: hw/extended_instruction_decoder.sv */
// execute logic for the extended instruction group and compare-skips
// assumes all inputs come from logic on mclk; words are presented in order
`timescale 1ns/1ns
`include "ext_decode_regs.svh"
module extended_instruction_decoder (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cfg_ext_bit,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] working_reg,
  input wire logic [7:0] operand_data,
  input wire logic [3:0] bank_select,
  input wire logic [12:0] pc_latch,
  input wire logic [20:0] return_addr,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic ext_enabled,
  output logic [2:0][11:0] file_select_pointer,
  output logic mem_re,
  output logic [11:0] mem_raddr,
  output logic mem_we,
  output logic [11:0] mem_waddr,
  output logic [7:0] mem_wdata,
  output logic ret_req,
  output logic call_req,
  output logic [20:0] call_target,
  output logic [20:0] push_addr,
  output logic skip,
  output logic oper_valid,
  output logic [11:0] oper_addr
);

  ext_decode_pkg::core_t s_reg;
  ext_decode_pkg::core_t s_next;
  ext_decode_pkg::decode_t d;
  logic take;
  logic take_ce;
  logic [11:0] k_ext;
  logic [11:0] z_ext;
  logic [11:0] f_ext;
  logic [11:0] frame;
  logic cmp_true;

  decode_if dbus ();

  assign dbus.word = instr_word;
  assign dbus.ext_en = s_reg.ext_on;
  assign d = dbus.d;

  instruction_classifier u_cls (
    .bus(dbus)
  );

  ////////////////////////////////////////////////////////////////////////////

  assign take = instr_valid && !s_reg.busy;
  assign take_ce = take && ce;
  assign k_ext = {6'h00, d.k6};
  assign z_ext = {5'h00, d.z};
  assign f_ext = {4'h0, d.f};
  assign frame = s_reg.ptr[`FRAME_SEL];
  assign cmp_true = (d.kind == ext_decode_pkg::op_cmp_gt)
    ? (operand_data > working_reg) : (operand_data < working_reg);

  always_comb begin
    s_next = s_reg;
    s_next.mem_re = 1'b0;
    s_next.mem_we = 1'b0;
    s_next.ret = 1'b0;
    s_next.call = 1'b0;
    s_next.skip = 1'b0;
    s_next.oper_valid = 1'b0;
    if (!s_reg.cfg_done) begin
      // config bit caught once after reset release
      s_next.ext_on = cfg_ext_bit;
      s_next.cfg_done = 1'b1;
      s_next.busy = 1'b0;
    end else begin
      case (s_reg.phase)
        ext_decode_pkg::st_hold: begin
          s_next.busy = 1'b0;
          s_next.phase = ext_decode_pkg::st_idle;
        end
        ext_decode_pkg::st_second: begin
          if (take) begin
            s_next.phase = ext_decode_pkg::st_idle;
            if (instr_word[`FLD_OP4] == `OPC_SECOND) begin
              s_next.mem_we = 1'b1;
              s_next.wdata = mem_rdata;
              s_next.waddr = s_reg.pair_ss
                ? frame + {5'h00, instr_word[`FLD_Z]}
                : instr_word[`FLD_FD];
            end
          end
        end
        ext_decode_pkg::st_skip: begin
          // flushed word, one more if it is two-word
          if (take) begin
            s_next.phase = d.two_word ? ext_decode_pkg::st_skip_tail
                                      : ext_decode_pkg::st_idle;
          end
        end
        ext_decode_pkg::st_skip_tail: begin
          if (take) begin
            s_next.phase = ext_decode_pkg::st_idle;
          end
        end
        ext_decode_pkg::st_idle: begin
          if (take) begin
            if (d.byte_op) begin
              s_next.oper_valid = 1'b1;
              if (d.indexed) begin
                s_next.oper_addr = frame + f_ext;
              end else if (!d.acc) begin
                s_next.oper_addr = {(d.f <= `ACCESS_LIMIT) ? `ACCESS_LO_BANK
                                    : `ACCESS_HI_BANK, d.f};
              end else begin
                s_next.oper_addr = {bank_select, d.f};
              end
            end
            case (d.kind)
              ext_decode_pkg::op_ptr_add: begin
                s_next.ptr[d.sel] = s_reg.ptr[d.sel] + k_ext;
              end
              ext_decode_pkg::op_ptr_sub: begin
                s_next.ptr[d.sel] = s_reg.ptr[d.sel] - k_ext;
              end
              ext_decode_pkg::op_frame_add_ret: begin
                s_next.ptr[`FRAME_SEL] = frame + k_ext;
                s_next.ret = 1'b1;
                s_next.busy = 1'b1;
                s_next.phase = ext_decode_pkg::st_hold;
              end
              ext_decode_pkg::op_frame_sub_ret: begin
                s_next.ptr[`FRAME_SEL] = frame - k_ext;
                s_next.ret = 1'b1;
                s_next.busy = 1'b1;
                s_next.phase = ext_decode_pkg::st_hold;
              end
              ext_decode_pkg::op_call_w: begin
                s_next.call = 1'b1;
                s_next.target = {pc_latch, working_reg};
                s_next.push_addr = return_addr;
                s_next.busy = 1'b1;
                s_next.phase = ext_decode_pkg::st_hold;
              end
              ext_decode_pkg::op_push_lit: begin
                s_next.mem_we = 1'b1;
                s_next.waddr = frame;
                s_next.wdata = d.k8;
                s_next.ptr[`FRAME_SEL] = frame - `PTR_STEP;
              end
              ext_decode_pkg::op_move_sf, ext_decode_pkg::op_move_ss: begin
                s_next.mem_re = 1'b1;
                s_next.raddr = frame + z_ext;
                s_next.pair_ss = (d.kind == ext_decode_pkg::op_move_ss);
                s_next.phase = ext_decode_pkg::st_second;
              end
              // true result flushes the next word
              ext_decode_pkg::op_cmp_gt, ext_decode_pkg::op_cmp_lt: begin
                if (cmp_true) begin
                  s_next.skip = 1'b1;
                  s_next.phase = ext_decode_pkg::st_skip;
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          s_next.phase = ext_decode_pkg::st_idle;
        end
      endcase
    end
  end

  // busy starts high so no word is taken before the config bit is caught
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.busy <= 1'b1;
      s_reg.ext_on <= `EXT_ERASED;
      s_reg.ptr <= {3{`PTR_RESET}};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign busy = s_reg.busy;
  assign ext_enabled = s_reg.ext_on;
  assign file_select_pointer = s_reg.ptr;
  assign mem_re = s_reg.mem_re;
  assign mem_raddr = s_reg.raddr;
  assign mem_we = s_reg.mem_we;
  assign mem_waddr = s_reg.waddr;
  assign mem_wdata = s_reg.wdata;
  assign ret_req = s_reg.ret;
  assign call_req = s_reg.call;
  assign call_target = s_reg.target;
  assign push_addr = s_reg.push_addr;
  assign skip = s_reg.skip;
  assign oper_valid = s_reg.oper_valid;
  assign oper_addr = s_reg.oper_addr;

  ////////////////////////////////////////////////////////////////////////////

  cfg_capture_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    rst_n && ce && !s_reg.cfg_done
    |=> ext_enabled == $past(cfg_ext_bit) && !busy)
    else $error("extension enable not taken from config bit");

  ext_gate_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !s_reg.ext_on |-> !(d.kind inside {ext_decode_pkg::op_ptr_add,
      ext_decode_pkg::op_ptr_sub, ext_decode_pkg::op_push_lit,
      ext_decode_pkg::op_call_w, ext_decode_pkg::op_move_sf}))
    else $error("extension opcode decoded while disabled");

  ptr_add_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_ptr_add && d.sel == 2'h0
    |=> file_select_pointer[0] == $past(file_select_pointer[0]) + $past(k_ext)
      && !busy)
    else $error("pointer add result wrong");

  ptr_sub_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_ptr_sub && d.sel == 2'h1
    |=> file_select_pointer[1] == $past(file_select_pointer[1]) - $past(k_ext)
      && !busy)
    else $error("pointer subtract result wrong");

  frame_ret_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_frame_add_ret
    |=> ret_req && busy
      && file_select_pointer[2] == $past(frame) + $past(k_ext))
    else $error("frame add and return wrong");

  frame_sub_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_frame_sub_ret
    |=> ret_req && busy
      && file_select_pointer[2] == $past(frame) - $past(k_ext)
      ##1 ($past(ce) ? !busy : busy))
    else $error("frame subtract and return wrong");

  call_w_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_call_w
    |=> call_req && busy && call_target == {$past(pc_latch), $past(working_reg)}
      && push_addr == $past(return_addr))
    else $error("call via working register wrong");

  push_lit_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_push_lit
    |=> mem_we && mem_waddr == $past(frame)
      && file_select_pointer[2] == $past(frame) - `PTR_STEP)
    else $error("literal push wrong");

  move_src_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind == ext_decode_pkg::op_move_sf
    |=> mem_re && mem_raddr == $past(frame) + $past(z_ext) && !mem_we)
    else $error("stack move source address wrong");

  skip_cmp_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle
      && d.kind inside {ext_decode_pkg::op_cmp_gt, ext_decode_pkg::op_cmp_lt}
    |=> skip == $past(cmp_true))
    else $error("compare skip decision wrong");

  index_addr_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle && d.indexed
    |=> oper_valid && oper_addr == $past(frame) + $past(f_ext))
    else $error("indexed operand address wrong");

  bank_addr_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    take_ce && s_reg.phase == ext_decode_pkg::st_idle && d.byte_op && d.acc
    |=> oper_addr == {$past(bank_select), $past(d.f)})
    else $error("banked operand address wrong");

endmodule

/* File: sim/tb.sv */
// self-checking bench for the extended instruction decoder
// assumes the hw header, package, interface and design are compiled first
`timescale 1ns/1ns
module tb;
  logic mclk;
  logic rst_n;
  logic ce;
  logic cfg_ext_bit;
  logic instr_valid;
  logic [15:0] instr_word;
  logic [7:0] working_reg;
  logic [7:0] operand_data;
  logic [3:0] bank_select;
  logic [12:0] pc_latch;
  logic [20:0] return_addr;
  logic [7:0] mem_rdata;
  logic busy, ext_enabled, mem_re, mem_we, ret_req, call_req, skip;
  logic oper_valid;
  logic [2:0][11:0] fsp;
  logic [11:0] mem_raddr, mem_waddr, oper_addr;
  logic [7:0] mem_wdata;
  logic [20:0] call_target, push_addr;
  int fails;
  int n_compared;
  int cycles;

  extended_instruction_decoder dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cfg_ext_bit(cfg_ext_bit),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .working_reg(working_reg),
    .operand_data(operand_data),
    .bank_select(bank_select),
    .pc_latch(pc_latch),
    .return_addr(return_addr),
    .mem_rdata(mem_rdata),
    .busy(busy),
    .ext_enabled(ext_enabled),
    .file_select_pointer(fsp),
    .mem_re(mem_re),
    .mem_raddr(mem_raddr),
    .mem_we(mem_we),
    .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata),
    .ret_req(ret_req),
    .call_req(call_req),
    .call_target(call_target),
    .push_addr(push_addr),
    .skip(skip),
    .oper_valid(oper_valid),
    .oper_addr(oper_addr)
  );

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one word, taken at the second edge; outputs looked at just after it
  task automatic issue(input logic [15:0] w, input logic [7:0] od);
    @(posedge mclk);
    instr_word <= w;
    operand_data <= od;
    instr_valid <= 1'h1;
    @(posedge mclk);
    instr_valid <= 1'h0;
    #1;
  endtask

  task automatic do_reset(input logic cfg);
    @(posedge mclk);
    rst_n <= 1'h0;
    cfg_ext_bit <= cfg;
    repeat (4) @(posedge mclk);
    #1;
    check(busy, 32'h1);
    check(fsp[2], 32'h0);
    check(ext_enabled, 32'h1);
    @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    #1;
    check(busy, 32'h0);
    check(ext_enabled, {31'h0, cfg});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ptr();
    issue(16'hE805, 8'h00);
    check(fsp[0], 32'h005);
    // word refused while clock enable low
    @(posedge mclk);
    ce <= 1'h0;
    instr_word <= 16'hE805;
    instr_valid <= 1'h1;
    @(posedge mclk);
    instr_valid <= 1'h0;
    ce <= 1'h1;
    #1;
    check(fsp[0], 32'h005);
    issue(16'hE943, 8'h00);
    check(fsp[1], 32'hFFD);
    check(fsp[0], 32'h005);
    issue(16'hE8BF, 8'h00);
    check(fsp[2], 32'h03F);
  endtask

  task automatic t_frame();
    // add, return, word during busy refused
    @(posedge mclk);
    instr_word <= 16'hE8C5;
    instr_valid <= 1'h1;
    @(posedge mclk);
    instr_word <= 16'hE801;
    #1;
    check(fsp[2], 32'h044);
    check(ret_req, 32'h1);
    check(busy, 32'h1);
    @(posedge mclk);
    instr_valid <= 1'h0;
    #1;
    check(busy, 32'h0);
    check(ret_req, 32'h0);
    check(fsp[0], 32'h005);
    issue(16'hE9C4, 8'h00);
    check(fsp[2], 32'h040);
    check(ret_req, 32'h1);
    check(busy, 32'h1);
    @(posedge mclk);
    #1;
    check(busy, 32'h0);
  endtask

  task automatic t_call_push();
    // target from latch and working value
    issue(16'h0014, 8'h00);
    check(call_req, 32'h1);
    check(call_target, 32'h1ABC50);
    check(push_addr, 32'h012345);
    check(busy, 32'h1);
    @(posedge mclk);
    #1;
    check(call_req, 32'h0);
    check(busy, 32'h0);
    // write at old pointer, then decrement
    issue(16'hEA7E, 8'h00);
    check(mem_we, 32'h1);
    check(mem_waddr, 32'h040);
    check(mem_wdata, 32'h7E);
    check(fsp[2], 32'h03F);
  endtask

  // source offset 5 from frame pointer 3F; second word back to back
  task automatic t_move(input logic [15:0] w1, input logic [15:0] w2,
                        input logic [31:0] we, input logic [31:0] wa);
    @(posedge mclk);
    instr_word <= w1;
    instr_valid <= 1'h1;
    @(posedge mclk);
    instr_word <= w2;
    #1;
    check(mem_re, 32'h1);
    check(mem_raddr, 32'h044);
    @(posedge mclk);
    instr_valid <= 1'h0;
    #1;
    check(mem_we, we);
    if (we == 32'h1) begin
      check(mem_waddr, wa);
      check(mem_wdata, 32'hC3);
    end
  endtask

  task automatic t_cmp();
    issue(16'h6580, 8'h90);
    check(skip, 32'h1);
    // access bit set uses bank select
    check(oper_addr, 32'h380);
    issue(16'hEA11, 8'h00);
    check(mem_we, 32'h0);
    check(fsp[2], 32'h03F);
    issue(16'h6480, 8'h50);
    check(skip, 32'h0);
    issue(16'h6180, 8'h90);
    check(skip, 32'h0);
    issue(16'hEA11, 8'h00);
    check(fsp[2], 32'h03E);
    issue(16'h6080, 8'h10);
    check(skip, 32'h1);
    check(oper_addr, 32'hF80);
    issue(16'hC123, 8'h00);
    issue(16'hEA22, 8'h00);
    check(mem_we, 32'h0);
    issue(16'hEA33, 8'h00);
    check(mem_we, 32'h1);
    check(fsp[2], 32'h03D);
  endtask

  task automatic t_index();
    // low operand indexed from frame pointer
    issue(16'h2410, 8'h00);
    check(oper_valid, 32'h1);
    check(oper_addr, 32'h04D);
    issue(16'h245F, 8'h00);
    check(oper_addr, 32'h09C);
    issue(16'h2460, 8'h00);
    check(oper_addr, 32'hF60);
    issue(16'h2510, 8'h00);
    check(oper_addr, 32'h310);
  endtask

  task automatic t_off();
    do_reset(1'h0);
    // extension words have no effect when off
    issue(16'hE805, 8'h00);
    check(fsp[0], 32'h000);
    issue(16'hEA7E, 8'h00);
    check(mem_we, 32'h0);
    issue(16'h2410, 8'h00);
    check(oper_addr, 32'h010);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    fails = 0;
    n_compared = 0;
    cycles = 0;
    rst_n = 1'h0;
    ce = 1'h1;
    cfg_ext_bit = 1'h1;
    instr_valid = 1'h0;
    instr_word = 16'h0000;
    working_reg = 8'h50;
    operand_data = 8'h00;
    bank_select = 4'h3;
    pc_latch = 13'h1ABC;
    return_addr = 21'h012345;
    mem_rdata = 8'hC3;
    do_reset(1'h1);
    t_ptr();
    t_frame();
    t_call_push();
    t_move(16'hEB05, 16'hF123, 32'h1, 32'h123);
    t_move(16'hEB85, 16'hF00A, 32'h1, 32'h049);
    t_move(16'hEB05, 16'h0123, 32'h0, 32'h000);
    t_cmp();
    t_index();
    t_off();
    end_sim();
  end
endmodule
